// ==== rtl/hosb_top.sv ====
// Host override and status bits: AC-good override, share clamp release,
// fault indicator drive and clear, and the monitor and overcurrent flags.
// Assumes a bus slave that presents one-cycle read and write strobes with
// an 8-bit register address, and configuration levels on this clock.
`timescale 1ns/10ps
module hosb_top (
   input wire logic clk,
   input wire logic resetn,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic monitor_input_one,
   input wire logic monitor_input_two,
   input wire logic monitor_input_three,
   input wire logic monitor_input_four,
   input wire logic monitor_input_five,
   input wire logic ac_sense_in,
   input wire logic host_mode,
   input wire logic ac_pass_through,
   input wire logic clamp_sel_88,
   input wire logic [7:0] ramp_level,
   input wire logic ocp_timeout,
   input wire logic fault_event,
   input wire logic latch_mode,
   input wire logic power_on_cycle,
   output logic ac_good_function,
   output logic share_clamp_release,
   output logic fault_indicator,
   output logic bus_alert
);
   // ------------------------------------------------------------
   // Helpers.
   // ------------------------------------------------------------
   // True when the address matches a register offset.
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // Ramp threshold as a fraction of the final value.
   function automatic logic [7:0] thr(input logic [15:0] pct);
      logic [15:0] p;
      p = 16'({8'h00, hosb_pkg::RAMP_FULL} * pct) / hosb_pkg::PCT_ALL;
      thr = p[7:0];
   endfunction

   // ------------------------------------------------------------
   // Reset release.
   // ------------------------------------------------------------
   logic rst_m_r; // First reset stage.
   logic rst_n_s; // Released reset used by the whole block.
   // The reset asserts at once and releases after two edges.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_m_r <= 1'b0;
         rst_n_s <= 1'b0;
      end else begin
         rst_m_r <= 1'b1;
         rst_n_s <= rst_m_r;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n_s);

   // ------------------------------------------------------------
   // Pin synchronisers.
   // ------------------------------------------------------------
   logic [4:0] mon_s; // Monitors five down to one, bit 0 is five.
   logic ac_s; // Synchronised AC sense.
   // Monitor pins pass two flip-flops before any logic reads them.
   hosb_sync #(.W(5)) u_mon_sync (
      .clk(clk),
      .rst_n(rst_n_s),
      .d({monitor_input_one, monitor_input_two, monitor_input_three,
          monitor_input_four, monitor_input_five}),
      .q(mon_s)
   );
   // The AC sense pin likewise.
   hosb_sync #(.W(1)) u_ac_sync (
      .clk(clk),
      .rst_n(rst_n_s),
      .d(ac_sense_in),
      .q(ac_s)
   );

   // ------------------------------------------------------------
   // Write decode.
   // ------------------------------------------------------------
   logic wr_acovr; // Write to the power and AC override byte.
   logic wr_clamp; // Write to the clamp and latch control byte.
   logic wr_fdrv; // Write to the fault output drive byte.
   assign wr_acovr = reg_wr && hit(reg_addr, hosb_pkg::OFS_ACOVR);
   assign wr_clamp = reg_wr && hit(reg_addr, hosb_pkg::OFS_CLAMP);
   assign wr_fdrv = reg_wr && hit(reg_addr, hosb_pkg::OFS_FDRV);

   // ------------------------------------------------------------
   // Override bits written by the host.
   // ------------------------------------------------------------
   logic ac_ovr_r; // AC-good override value.
   logic clamp_ovr_r; // Share clamp release from the host.
   logic fdrv_r; // Fault indicator drive from the host.
   logic ac_ovr_nxt;
   logic clamp_ovr_nxt;
   logic fdrv_nxt;
   // Each write-only bit takes the written value on its own write.
   always_comb begin
      ac_ovr_nxt = ac_ovr_r;
      clamp_ovr_nxt = clamp_ovr_r;
      fdrv_nxt = fdrv_r;
      if (wr_acovr) begin
         ac_ovr_nxt = reg_wdata[hosb_pkg::BIT_ACOVR];
      end
      if (wr_clamp) begin
         clamp_ovr_nxt = reg_wdata[hosb_pkg::BIT_CLAMP];
      end
      if (wr_fdrv) begin
         fdrv_nxt = reg_wdata[hosb_pkg::BIT_FDRV];
      end
   end
   // Override registers.
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         ac_ovr_r <= hosb_pkg::RST_BYTE[0];
         clamp_ovr_r <= hosb_pkg::RST_BYTE[0];
         fdrv_r <= hosb_pkg::RST_BYTE[0];
      end else begin
         ac_ovr_r <= ac_ovr_nxt;
         clamp_ovr_r <= clamp_ovr_nxt;
         fdrv_r <= fdrv_nxt;
      end
   end

   // ------------------------------------------------------------
   // Overcurrent timed-out flag.
   // ------------------------------------------------------------
   logic ocp_r; // Sticky until the power-on control cycles.
   logic ocp_nxt;
   // A timeout wins over a power-on cycle in the same clock.
   always_comb begin
      if (ocp_timeout) begin
         ocp_nxt = 1'b1;
      end else if (power_on_cycle) begin
         ocp_nxt = 1'b0;
      end else begin
         ocp_nxt = ocp_r;
      end
   end
   // Flag register.
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         ocp_r <= 1'b0;
      end else begin
         ocp_r <= ocp_nxt;
      end
   end

   // ------------------------------------------------------------
   // Fault indicator latch.
   // ------------------------------------------------------------
   hosb_fault_if fif ();
   // Only a one in the clear bit clears; a power-on cycle clears too.
   assign fif.clr_req = (wr_clamp && reg_wdata[hosb_pkg::BIT_CLR])
      || power_on_cycle;
   assign fif.set_evt = fault_event;
   assign fif.latch_mode = latch_mode;
   hosb_fault_latch u_latch (
      .clk(clk),
      .rst_n(rst_n_s),
      .f(fif.lat)
   );

   // ------------------------------------------------------------
   // Outputs to the supervisory logic and pins.
   // ------------------------------------------------------------
   logic acg_r; // AC-good function.
   logic clr_r; // Share clamp release.
   logic fi_r; // Fault indicator pin.
   logic alert_r; // Bus alert.
   logic acg_nxt;
   logic clr_nxt;
   logic fi_nxt;
   logic alert_nxt;
   logic [7:0] ramp_thr; // Default release point.
   assign ramp_thr = clamp_sel_88 ? thr(hosb_pkg::PCT_HI) : thr(hosb_pkg::PCT_LO);
   // Host mode swaps the AC sense and ramp results for the host's bits.
   always_comb begin
      if (host_mode) begin
         acg_nxt = ac_ovr_r;
         clr_nxt = clamp_ovr_r;
      end else begin
         // Without pass-through the sense is only reported.
         acg_nxt = ac_pass_through && ac_s;
         clr_nxt = (ramp_level >= ramp_thr);
      end
      fi_nxt = fif.latched || fdrv_r;
      alert_nxt = fif.latched;
   end
   // Output registers.
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         acg_r <= 1'b0;
         clr_r <= 1'b0;
         fi_r <= 1'b0;
         alert_r <= 1'b0;
      end else begin
         acg_r <= acg_nxt;
         clr_r <= clr_nxt;
         fi_r <= fi_nxt;
         alert_r <= alert_nxt;
      end
   end
   assign ac_good_function = acg_r;
   assign share_clamp_release = clr_r;
   assign fault_indicator = fi_r;
   assign bus_alert = alert_r;

   // ------------------------------------------------------------
   // Read path.
   // ------------------------------------------------------------
   logic [7:0] rd_r; // Read data, valid the cycle after the strobe.
   logic [7:0] rd_nxt;
   // Write-only and unmapped bytes read zero.
   always_comb begin
      rd_nxt = rd_r;
      if (reg_rd) begin
         rd_nxt = 8'h00;
         if (hit(reg_addr, hosb_pkg::OFS_FLAGS)) begin
            rd_nxt[hosb_pkg::BIT_MON_LSB +: 5] = mon_s;
            rd_nxt[hosb_pkg::BIT_OCP] = ocp_r;
         end else if (hit(reg_addr, hosb_pkg::OFS_ACRD)) begin
            rd_nxt[hosb_pkg::BIT_ACRD] = ac_s;
         end
      end
   end
   // Read data register.
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         rd_r <= hosb_pkg::RST_BYTE;
      end else begin
         rd_r <= rd_nxt;
      end
   end
   assign reg_rdata = rd_r;

   // ------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------
   logic w_acovr; // Written AC override bit.
   logic w_clamp; // Written clamp bit.
   assign w_acovr = reg_wdata[hosb_pkg::BIT_ACOVR];
   assign w_clamp = reg_wdata[hosb_pkg::BIT_CLAMP];

   // A host write takes over AC-good two cycles after its strobe.
   ac_override_a: assert property (
      wr_acovr && host_mode ##1 host_mode && !wr_acovr
      |=> ac_good_function == $past(w_acovr, 2))
      else $error("AC-good did not follow host write");
   ac_sense_only_a: assert property (
      !host_mode && !ac_pass_through |=> !ac_good_function)
      else $error("AC sense leaked into AC-good");
   // A host write takes over the clamp release two cycles after its strobe.
   clamp_override_a: assert property (
      wr_clamp && host_mode ##1 host_mode && !wr_clamp
      |=> share_clamp_release == $past(w_clamp, 2))
      else $error("clamp did not follow host write");
   clamp_default_a: assert property (
      !host_mode |=> share_clamp_release == ($past(ramp_level) >= $past(ramp_thr)))
      else $error("default clamp release wrong");
   fault_drive_a: assert property (
      wr_fdrv && reg_wdata[hosb_pkg::BIT_FDRV] |=> ##1 fault_indicator)
      else $error("fault indicator not driven");
   alert_clear_a: assert property (
      fif.clr_req && !fault_event |=> ##1 !bus_alert && !fault_indicator || $past(fdrv_r))
      else $error("alert not cleared");
   // A read of the flag byte returns the synchronised monitor levels.
   mon_flags_a: assert property (
      reg_rd && hit(reg_addr, hosb_pkg::OFS_FLAGS) |=> reg_rdata[4:0] == $past(mon_s))
      else $error("monitor flags wrong");
   ocp_flag_a: assert property (
      ocp_timeout ##1 reg_rd && hit(reg_addr, hosb_pkg::OFS_FLAGS) |=> reg_rdata[5])
      else $error("overcurrent flag missing");
   ac_read_a: assert property (
      reg_rd && hit(reg_addr, hosb_pkg::OFS_ACRD) |=> reg_rdata == {$past(ac_s), 7'h00})
      else $error("AC sense flag wrong");
   wo_zero_a: assert property (
      reg_rd && (hit(reg_addr, hosb_pkg::OFS_CLAMP) || hit(reg_addr, hosb_pkg::OFS_FDRV))
      |=> reg_rdata == 8'h00)
      else $error("write-only byte read nonzero");
   // The overcurrent flag stays set until the power-on control cycles.
   ocp_sticky_a: assert property (
      ocp_r && !power_on_cycle |=> ocp_r)
      else $error("overcurrent flag dropped early");
   // With pass-through the synchronised sense reaches AC-good.
   ac_pass_a: assert property (
      !host_mode && ac_pass_through |=> ac_good_function == $past(ac_s))
      else $error("AC sense not passed through");
   // A zero in the clear bit leaves a latched fault alone.
   zero_clear_a: assert property (
      wr_clamp && !reg_wdata[hosb_pkg::BIT_CLR] && !power_on_cycle && fif.latched
      && latch_mode |=> fif.latched)
      else $error("zero clear emptied fault latch");
endmodule

// ==== rtl/hosb_pkg.sv ====
// Constants for the host override and status bits of the supply controller.
// Assumes the management bus slave hands over decoded byte reads and writes.
// Function
// - Host bit drives AC-good in host mode.
// - AC sense reported without feeding AC-good; with pass-through it feeds AC-good.
// - Host bit sets share clamp release in host mode.
// - Default clamp release at 75 or 88%.
// - Host bit drives the fault indicator pin.
// - Clear bit clears latch and bus alert.
// - Flags 0..4 show monitors five to one.
// - Flag 5 shows overcurrent timed out.
// - Flag 7 of 02h shows AC sense.
package hosb_pkg;
   // ------------------------------------------------------------
   // Register offsets.
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_FLAGS = 8'h00; // Monitor and overcurrent flags.
   localparam logic [7:0] OFS_ACRD = 8'h02; // AC sense read flag.
   localparam logic [7:0] OFS_ACOVR = 8'h12; // Power and AC override.
   localparam logic [7:0] OFS_CLAMP = 8'h13; // Clamp and latch control.
   localparam logic [7:0] OFS_FDRV = 8'h1b; // Fault output drive.
   // ------------------------------------------------------------
   // Field positions and reset values.
   // ------------------------------------------------------------
   localparam int BIT_MON_LSB = 0; // Monitor five sits here, monitor one at 4.
   localparam int BIT_OCP = 5; // Overcurrent timed out.
   localparam int BIT_ACRD = 7; // AC sense state.
   localparam int BIT_ACOVR = 5; // AC-good override value.
   localparam int BIT_CLAMP = 2; // Share clamp release.
   localparam int BIT_CLR = 0; // Fault latch clear.
   localparam int BIT_FDRV = 1; // Fault indicator drive.
   localparam logic [7:0] RST_BYTE = 8'h00; // Reset value of every byte.
   // ------------------------------------------------------------
   // Soft-start ramp thresholds.
   // ------------------------------------------------------------
   localparam logic [7:0] RAMP_FULL = 8'hff; // Final ramp value.
   localparam logic [15:0] PCT_LO = 16'h004b; // 75 percent.
   localparam logic [15:0] PCT_HI = 16'h0058; // 88 percent.
   localparam logic [15:0] PCT_ALL = 16'h0064; // 100 percent.
   // Fault latch states.
   typedef enum logic [1:0] {
      HOSB_LAT_CLEAR = 2'b01,
      HOSB_LAT_SET = 2'b10
   } hosb_lat_type;
endpackage

// ==== rtl/hosb_fault_if.sv ====
// Interface between the register bank and the fault indicator latch.
// Assumes both ends share one clock and reset.
`timescale 1ns/10ps
interface hosb_fault_if;
   logic set_evt; // Fault event, a one-cycle or longer level.
   logic clr_req; // Clear request, one cycle.
   logic latch_mode; // High when the indicator latches.
   logic latched; // Latch state.
   // Register bank side.
   modport ctl (output set_evt, output clr_req, output latch_mode, input latched);
   // Latch side.
   modport lat (input set_evt, input clr_req, input latch_mode, output latched);
endinterface

// ==== rtl/hosb_sync.sv ====
// Two flip-flop synchroniser for pin inputs.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/10ps
module hosb_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r; // First stage, read only by the second.
   logic [W-1:0] q_r; // Second stage.
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_nxt;
   // Next values of both stages.
   always_comb begin
      meta_nxt = d;
      q_nxt = meta_r;
   end
   // Registers of both stages.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         q_r <= q_nxt;
      end
   end
   assign q = q_r;
endmodule

// ==== rtl/hosb_fault_latch.sv ====
// Fault indicator latch with set priority over clear.
// Assumes a synchronous clear request from the register bank.
`timescale 1ns/10ps
module hosb_fault_latch (
   input wire logic clk,
   input wire logic rst_n,
   hosb_fault_if.lat f
);
   hosb_pkg::hosb_lat_type st_r; // Latch state.
   hosb_pkg::hosb_lat_type st_nxt;
   // An event wins over a clear in the same cycle; without latching the
   // indicator follows the event.
   always_comb begin
      case (st_r)
         hosb_pkg::HOSB_LAT_CLEAR: begin
            st_nxt = f.set_evt ? hosb_pkg::HOSB_LAT_SET : hosb_pkg::HOSB_LAT_CLEAR;
         end
         hosb_pkg::HOSB_LAT_SET: begin
            if (f.set_evt) begin
               st_nxt = hosb_pkg::HOSB_LAT_SET;
            end else if (f.clr_req || !f.latch_mode) begin
               st_nxt = hosb_pkg::HOSB_LAT_CLEAR;
            end else begin
               st_nxt = hosb_pkg::HOSB_LAT_SET;
            end
         end
         default: begin
            st_nxt = hosb_pkg::HOSB_LAT_CLEAR;
         end
      endcase
   end
   // State register.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= hosb_pkg::HOSB_LAT_CLEAR;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign f.latched = (st_r == hosb_pkg::HOSB_LAT_SET);
   // A clear without an event empties the latch.
   latch_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      f.clr_req && !f.set_evt |=> !f.latched)
      else $error("fault latch not cleared");
   // A latched fault holds until cleared.
   latch_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      f.latched && f.latch_mode && !f.clr_req |=> f.latched)
      else $error("fault latch lost without clear");
endmodule

// ==== sim/hosb_host_model.sv ====
// Behavioural host microcontroller that reaches the override bank's register port.
// Assumes the bank takes one-cycle read and write strobes on rising clk edges.
`timescale 1ns/10ps
module hosb_host_model (
   input wire logic clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   // ------------------------------------------------------------
   // Bus cycles.
   // ------------------------------------------------------------
   // The port starts idle with no strobe raised.
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // One write; address and data are inverted when released so stale values never match.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   // One read; the byte is taken one cycle after the strobe is accepted.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(posedge clk);
      #1 d = reg_rdata;
   endtask
   // ------------------------------------------------------------
   // Host duties.
   // ------------------------------------------------------------
   // Polls the AC sense flag and writes the matching AC-good override.
   task automatic poll_ac;
      logic [7:0] v;
      logic [7:0] w;
      rd(hosb_pkg::OFS_ACRD, v);
      w = 8'h00;
      w[hosb_pkg::BIT_ACOVR] = v[hosb_pkg::BIT_ACRD];
      wr(hosb_pkg::OFS_ACOVR, w);
   endtask
   // Clears a latched fault indicator; the clamp bit is written low with it.
   task automatic clear_latch;
      logic [7:0] w;
      w = 8'h00;
      w[hosb_pkg::BIT_CLR] = 1'b1;
      wr(hosb_pkg::OFS_CLAMP, w);
   endtask
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the host override and status bits.
// Assumes the host model drives the register port and the bench drives all pins.
`timescale 1ns/10ps
module testbench;
   logic clk, resetn, ac_sense_in, host_mode, ac_pass_through, clamp_sel_88;
   logic ocp_timeout, fault_event, latch_mode, power_on_cycle;
   logic [4:0] mon; // Bit 0 is monitor one, bit 4 monitor five.
   logic [7:0] ramp_level;
   logic reg_wr, reg_rd, ac_good_function, share_clamp_release, fault_indicator, bus_alert;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
   int fail_count = 0;
   int comparisons = 0;
   int r;
   int ramps [6] = '{190, 191, 223, 224, 0, 255}; // Threshold boundaries and ends.
   // ------------------------------------------------------------
   // Clock, design and host.
   // ------------------------------------------------------------
   // The clock toggles every half period of 2.5 ns.
   initial clk = 1'b0;
   always #2.5 clk = ~clk;
   hosb_top u_dut (.clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .monitor_input_one(mon[0]), .monitor_input_two(mon[1]), .monitor_input_three(mon[2]),
      .monitor_input_four(mon[3]), .monitor_input_five(mon[4]), .ac_sense_in(ac_sense_in),
      .host_mode(host_mode), .ac_pass_through(ac_pass_through), .clamp_sel_88(clamp_sel_88),
      .ramp_level(ramp_level), .ocp_timeout(ocp_timeout), .fault_event(fault_event),
      .latch_mode(latch_mode), .power_on_cycle(power_on_cycle),
      .ac_good_function(ac_good_function), .share_clamp_release(share_clamp_release),
      .fault_indicator(fault_indicator), .bus_alert(bus_alert));
   hosb_host_model u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   // ------------------------------------------------------------
   // Expectations and comparisons.
   // ------------------------------------------------------------
   // Flag byte: monitor five at bit 0 up to monitor one at bit 4, overcurrent at bit 5.
   function automatic logic [7:0] exp_flags(input logic [4:0] m, input logic ocp);
      logic [7:0] f;
      f = 8'h00;
      for (int i = 0; i < 5; i++) f[4 - i] = m[i];
      f[hosb_pkg::BIT_OCP] = ocp;
      return f;
   endfunction
   // Default clamp release once the ramp reaches the selected share of full scale.
   function automatic logic exp_clamp(input logic [7:0] ramp, input logic sel);
      int thr;
      thr = int'(hosb_pkg::RAMP_FULL) * int'(sel ? hosb_pkg::PCT_HI : hosb_pkg::PCT_LO) / 100;
      return int'(ramp) >= thr;
   endfunction
   // Compares a register byte.
   task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   // Compares a single output pin.
   task automatic chk_bit(input string n, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %b seen %b", n, e, g);
      end
   endtask
   // Lets n edges pass and samples once their updates have landed.
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic close_out;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // A hang is cut short long after the tests should have ended.
   initial begin
      #100000;
      fail_count++;
      close_out();
   end
   // ------------------------------------------------------------
   // Main sequence.
   // ------------------------------------------------------------
   initial begin
      r = $urandom(22);
      {resetn, ac_sense_in, host_mode, ac_pass_through, clamp_sel_88} = 5'h00;
      {ocp_timeout, fault_event, latch_mode, power_on_cycle} = 4'h0;
      mon = 5'h00;
      ramp_level = 8'h00;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      wait_n(4);
      chk_bit("fault_indicator", 1'b0, fault_indicator);
      // Monitor flags, a lone monitor one first, then random patterns.
      for (int i = 0; i < 7; i++) begin
         @(posedge clk);
         mon <= (i == 0) ? 5'h01 : 5'($urandom);
         wait_n(5);
         u_host.rd(hosb_pkg::OFS_FLAGS, v);
         chk_byte("flags", exp_flags(mon, 1'b0), v);
      end
      u_host.wr(hosb_pkg::OFS_FLAGS, 8'hff);
      u_host.rd(hosb_pkg::OFS_FLAGS, v);
      chk_byte("flags after write", exp_flags(mon, 1'b0), v);
      // Overcurrent timeout pulse, read at once, stays flagged until power is cycled.
      @(posedge clk);
      ocp_timeout <= 1'b1;
      fork
         u_host.rd(hosb_pkg::OFS_FLAGS, v);
         begin
            @(posedge clk);
            ocp_timeout <= 1'b0;
         end
      join
      chk_byte("flags ocp at once", exp_flags(mon, 1'b1), v);
      wait_n(10);
      u_host.rd(hosb_pkg::OFS_FLAGS, v);
      chk_byte("flags ocp", exp_flags(mon, 1'b1), v);
      @(posedge clk);
      power_on_cycle <= 1'b1;
      @(posedge clk);
      power_on_cycle <= 1'b0;
      wait_n(3);
      u_host.rd(hosb_pkg::OFS_FLAGS, v);
      chk_byte("flags ocp cleared", exp_flags(mon, 1'b0), v);
      // AC sense is reported without reaching AC-good, then passed through.
      @(posedge clk);
      ac_sense_in <= 1'b1;
      wait_n(6);
      u_host.rd(hosb_pkg::OFS_ACRD, v);
      chk_byte("ac read", 8'h80, v);
      chk_bit("ac_good sense only", 1'b0, ac_good_function);
      @(posedge clk);
      ac_pass_through <= 1'b1;
      wait_n(6);
      chk_bit("ac_good pass", 1'b1, ac_good_function);
      // Host mode: the override bit replaces the sensed value, both ways.
      @(posedge clk);
      host_mode <= 1'b1;
      wait_n(3);
      chk_bit("ac_good override off", 1'b0, ac_good_function);
      u_host.poll_ac();
      wait_n(3);
      chk_bit("ac_good override on", 1'b1, ac_good_function);
      @(posedge clk);
      ac_sense_in <= 1'b0;
      wait_n(6);
      u_host.poll_ac();
      wait_n(3);
      chk_bit("ac_good override low", 1'b0, ac_good_function);
      u_host.rd(hosb_pkg::OFS_ACOVR, v);
      chk_byte("override read", 8'h00, v);
      // Default clamp release at both thresholds, boundaries and random ramps.
      @(posedge clk);
      host_mode <= 1'b0;
      for (int s = 0; s < 2; s++) begin
         for (int k = 0; k < 10; k++) begin
            @(posedge clk);
            clamp_sel_88 <= s[0];
            ramp_level <= (k < 6) ? 8'(ramps[k]) : 8'($urandom);
            wait_n(3);
            chk_bit("clamp default", exp_clamp(ramp_level, clamp_sel_88), share_clamp_release);
         end
      end
      // Host writes take over the clamp release even with the ramp at full scale.
      @(posedge clk);
      host_mode <= 1'b1;
      ramp_level <= 8'hff;
      u_host.wr(hosb_pkg::OFS_CLAMP, 8'h00);
      wait_n(3);
      chk_bit("clamp held", 1'b0, share_clamp_release);
      u_host.wr(hosb_pkg::OFS_CLAMP, 8'h04);
      wait_n(3);
      chk_bit("clamp released", 1'b1, share_clamp_release);
      u_host.rd(hosb_pkg::OFS_CLAMP, v);
      chk_byte("clamp read", 8'h00, v);
      // Direct drive of the fault indicator pin without any alert.
      u_host.wr(hosb_pkg::OFS_FDRV, 8'h02);
      wait_n(3);
      chk_bit("indicator driven", 1'b1, fault_indicator);
      chk_bit("alert idle", 1'b0, bus_alert);
      u_host.wr(hosb_pkg::OFS_FDRV, 8'hfd);
      wait_n(3);
      chk_bit("indicator undriven", 1'b0, fault_indicator);
      u_host.rd(hosb_pkg::OFS_FDRV, v);
      chk_byte("drive read", 8'h00, v);
      // Without latching the indicator follows the event and drops with it.
      @(posedge clk);
      fault_event <= 1'b1;
      wait_n(3);
      chk_bit("indicator follows", 1'b1, fault_indicator);
      @(posedge clk);
      fault_event <= 1'b0;
      wait_n(3);
      chk_bit("indicator drops", 1'b0, fault_indicator);
      // Latched fault survives a zero clear and goes with a one.
      @(posedge clk);
      latch_mode <= 1'b1;
      fault_event <= 1'b1;
      @(posedge clk);
      fault_event <= 1'b0;
      wait_n(4);
      chk_bit("latched indicator", 1'b1, fault_indicator);
      chk_bit("latched alert", 1'b1, bus_alert);
      u_host.wr(hosb_pkg::OFS_CLAMP, 8'h04);
      wait_n(3);
      chk_bit("alert after zero clear", 1'b1, bus_alert);
      u_host.clear_latch();
      wait_n(3);
      chk_bit("indicator cleared", 1'b0, fault_indicator);
      chk_bit("alert cleared", 1'b0, bus_alert);
      u_host.rd(8'h05, v);
      chk_byte("unmapped read", 8'h00, v);
      close_out();
   end
endmodule
